/* ald_addsub8.sv */
// Purpose: 8-bit adder and subtractor with carry, half carry and overflow
// Assumes: Purely combinational, shared by byte and word operations
// Notes: In subtract mode carry in and carry out mean borrow
module ald_addsub8 (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic sub,
  // Results
  output logic [7:0] sum,
  output logic carryOut,
  output logic halfCarry,
  output logic overflow
);

  logic [7:0] cinWide;

  assign cinWide = {7'h00, cin};
  assign sum = sub ? 8'(a - b - cinWide) : 8'(a + b + cinWide);

  always_comb begin
    if (sub) begin
      carryOut = (~a[7] & b[7]) | (b[7] & sum[7]) | (sum[7] & ~a[7]);
      halfCarry = (~a[3] & b[3]) | (b[3] & sum[3]) | (sum[3] & ~a[3]);
      overflow = (a[7] & ~b[7] & ~sum[7]) | (~a[7] & b[7] & sum[7]);
    end else begin
      carryOut = (a[7] & b[7]) | (b[7] & ~sum[7]) | (~sum[7] & a[7]);
      halfCarry = (a[3] & b[3]) | (b[3] & ~sum[3]) | (~sum[3] & a[3]);
      overflow = (a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]);
    end
  end

endmodule

/* ald_consts.svh */
// Purpose: Shared numeric constants of the arithmetic and logic datapath
// Assumes: Included by its bare name wherever a constant is needed
// Notes: Definitions only
`ifndef ALD_CONSTS_SVH
`define ALD_CONSTS_SVH

// ****************************************
// Status register bit positions
// ****************************************
`define ALD_SREG_C 3'h0
`define ALD_SREG_Z 3'h1
`define ALD_SREG_N 3'h2
`define ALD_SREG_V 3'h3
`define ALD_SREG_S 3'h4
`define ALD_SREG_H 3'h5
`define ALD_SREG_T 3'h6
`define ALD_SREG_I 3'h7

// ****************************************
// Reset values and limits
// ****************************************
`define ALD_SREG_RESET 8'h00
`define ALD_FLAGS_RESET 8'h00
`define ALD_BYTE_ZERO 8'h00
`define ALD_IO_BITOP_LAST 6'h1F
`define ALD_FLAG_IO_ADDR_DEF 5'h0E
`define ALD_WORD_IMM_MASK 8'h3F

`endif

/* ald_datapath.sv */
// Purpose: Arithmetic and logic instruction datapath of an 8-bit core
// Assumes: Decoder presents operands already read from the register file
// Notes: Results are registered; word operations occupy two cycles
//
// Functional notes
// - Add registers, optional carry, flags ZCNVH, one cycle
// - Word add immediate, flags ZCNVS, two cycles
// - Subtract registers, optional carry, ZCNVH, one cycle
// - Subtract immediate, flags ZCNVH, one cycle
// - Subtract immediate and carry, ZCNVH, one cycle
// - Word subtract immediate, flags ZCNVS, two cycles
// - AND register or constant, flags ZNV, one cycle
// - OR, OR constant, XOR; flags ZNV, one cycle
// - Writing one clears a status flag; zero keeps
// - I/O bit ops rewrite whole register, clearing flags
// - I/O bit ops reach addresses 0 to 31 only
`include "ald_consts.svh"

module ald_datapath #(
  parameter logic [4:0] FLAG_IO_ADDR = `ALD_FLAG_IO_ADDR_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Operation request from decoder
  input wire logic opValid,
  input wire ald_pkg::ald_op_t opCode,
  input wire logic [7:0] opDst,
  input wire logic [7:0] opDstHigh,
  input wire logic [7:0] opSrc,
  // I/O bit operation operands
  input wire logic [5:0] ioAddr,
  input wire logic [2:0] ioBitSel,
  input wire logic [7:0] ioReadData,
  // Peripheral events raising local flags
  input wire logic [7:0] flagEvent,
  // Answer to decoder
  output logic opReady,
  output logic resultValid,
  output logic resultWord,
  output logic [7:0] resultLow,
  output logic [7:0] resultHigh,
  output logic [7:0] sreg,
  // I/O write back
  output logic ioWriteValid,
  output logic [4:0] ioWriteAddr,
  output logic [7:0] ioWriteData,
  output logic ioRefused,
  // Local write-one-to-clear flags
  output logic [7:0] flagStatus
);
  import ald_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (FLAG_IO_ADDR > `ALD_IO_BITOP_LAST) begin : g_bad_flag_addr
    $error("FLAG_IO_ADDR must lie within the bit-addressable I/O range");
  end

  ald_regs_t cur;
  ald_regs_t next_cur;

  // ****************************************
  // Shared adder input selection
  // ****************************************
  logic inHigh;
  logic isWord;
  logic isSubOp;
  logic useCarry;
  logic [7:0] aluA;
  logic [7:0] aluB;
  logic aluCin;
  logic aluSub;
  logic [7:0] aluSum;
  logic aluCarry;
  logic aluHalf;
  logic aluOvf;

  assign inHigh = (cur.state == ST_WORD_HIGH);
  assign isWord = (opCode == OP_WORD_ADD_IMM) || (opCode == OP_WORD_SUB_IMM);
  assign isSubOp = (opCode == OP_SUB) || (opCode == OP_SUB_IMM) || (opCode == OP_SUB_CARRY)
    || (opCode == OP_SUB_IMM_CARRY) || (opCode == OP_WORD_SUB_IMM);
  assign useCarry = (opCode == OP_ADD_CARRY) || (opCode == OP_SUB_CARRY) || (opCode == OP_SUB_IMM_CARRY);

  // High pass of a word op applies only the low-byte carry or borrow to the upper byte
  assign aluA = inHigh ? cur.wordHigh : opDst;
  assign aluB = inHigh ? `ALD_BYTE_ZERO : (isWord ? (opSrc & `ALD_WORD_IMM_MASK) : opSrc);
  assign aluCin = inHigh ? cur.lowCarry : (useCarry & cur.sreg[`ALD_SREG_C]);
  assign aluSub = inHigh ? cur.wordSub : isSubOp;

  ald_addsub8 u_addsub (
    .a(aluA),
    .b(aluB),
    .cin(aluCin),
    .sub(aluSub),
    .sum(aluSum),
    .carryOut(aluCarry),
    .halfCarry(aluHalf),
    .overflow(aluOvf)
  );

  // ****************************************
  // Logic unit and I/O bit operation
  // ****************************************
  logic [7:0] logicRes;
  logic [7:0] bitMask;
  logic [7:0] ioBase;
  logic [7:0] ioNew;
  logic ioLocal;

  always_comb begin
    unique case (opCode)
      OP_AND, OP_AND_IMM: logicRes = opDst & opSrc;
      OP_OR, OP_OR_IMM: logicRes = opDst | opSrc;
      default: logicRes = opDst ^ opSrc;
    endcase
  end

  assign bitMask = 8'(8'h01 << ioBitSel);
  assign ioLocal = (ioAddr[4:0] == FLAG_IO_ADDR);
  // Local flags are read from here, others come from the decoder's read
  assign ioBase = ioLocal ? cur.flags : ioReadData;
  assign ioNew = (opCode == OP_IO_BIT_SET) ? (ioBase | bitMask) : (ioBase & ~bitMask);

  // ****************************************
  // Next state
  // ****************************************
  logic [7:0] flagClear;
  logic hiR15;
  logic hiDst15;

  always_comb begin
    next_cur = cur;
    next_cur.resValid = 1'b0;
    next_cur.ioWrValid = 1'b0;
    next_cur.ioRefused = 1'b0;
    flagClear = `ALD_BYTE_ZERO;
    hiR15 = aluSum[7];
    hiDst15 = cur.wordHigh[7];
    unique case (cur.state)
      ST_IDLE: begin
        if (opValid) begin
          unique case (opCode)
            OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_IMM, OP_SUB_CARRY, OP_SUB_IMM_CARRY: begin
              // Flags S, T and I are left alone
              next_cur.resLow = aluSum;
              next_cur.resWord = 1'b0;
              next_cur.resValid = 1'b1;
              next_cur.sreg[`ALD_SREG_Z] = (aluSum == `ALD_BYTE_ZERO);
              next_cur.sreg[`ALD_SREG_C] = aluCarry;
              next_cur.sreg[`ALD_SREG_N] = aluSum[7];
              next_cur.sreg[`ALD_SREG_V] = aluOvf;
              next_cur.sreg[`ALD_SREG_H] = aluHalf;
            end
            OP_WORD_ADD_IMM, OP_WORD_SUB_IMM: begin
              // Low byte now, upper byte and flags ZCNVS next cycle
              next_cur.resLow = aluSum;
              next_cur.lowCarry = aluCarry;
              next_cur.wordHigh = opDstHigh;
              next_cur.wordSub = isSubOp;
              next_cur.state = ST_WORD_HIGH;
              next_cur.ready = 1'b0;
            end
            OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR: begin
              next_cur.resLow = logicRes;
              next_cur.resWord = 1'b0;
              next_cur.resValid = 1'b1;
              next_cur.sreg[`ALD_SREG_Z] = (logicRes == `ALD_BYTE_ZERO);
              next_cur.sreg[`ALD_SREG_N] = logicRes[7];
              next_cur.sreg[`ALD_SREG_V] = 1'b0;
            end
            OP_IO_BIT_CLEAR, OP_IO_BIT_SET: begin
              if (ioAddr > `ALD_IO_BITOP_LAST) begin
                next_cur.ioRefused = 1'b1;
              end else begin
                next_cur.ioWrValid = 1'b1;
                next_cur.ioWrAddr = ioAddr[4:0];
                next_cur.ioWrData = ioNew;
                if (ioLocal) begin
                  flagClear = ioNew;
                end
              end
            end
            default: begin
              next_cur.ready = 1'b1;
            end
          endcase
        end
      end
      ST_WORD_HIGH: begin
        next_cur.resHigh = aluSum;
        next_cur.resWord = 1'b1;
        next_cur.resValid = 1'b1;
        next_cur.state = ST_IDLE;
        next_cur.ready = 1'b1;
        next_cur.sreg[`ALD_SREG_Z] = ({aluSum, cur.resLow} == 16'h0000);
        next_cur.sreg[`ALD_SREG_N] = hiR15;
        if (cur.wordSub) begin
          next_cur.sreg[`ALD_SREG_V] = hiDst15 & ~hiR15;
          next_cur.sreg[`ALD_SREG_C] = hiR15 & ~hiDst15;
          next_cur.sreg[`ALD_SREG_S] = (hiR15 ^ (hiDst15 & ~hiR15));
        end else begin
          next_cur.sreg[`ALD_SREG_V] = ~hiDst15 & hiR15;
          next_cur.sreg[`ALD_SREG_C] = ~hiR15 & hiDst15;
          next_cur.sreg[`ALD_SREG_S] = (hiR15 ^ (~hiDst15 & hiR15));
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
        next_cur.ready = 1'b1;
      end
    endcase
    // A new event beats a clear in the same cycle
    next_cur.flags = (cur.flags & ~flagClear) | flagEvent;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur.state <= ST_IDLE;
      cur.ready <= 1'b1;
      cur.sreg <= `ALD_SREG_RESET;
      cur.resLow <= `ALD_BYTE_ZERO;
      cur.resHigh <= `ALD_BYTE_ZERO;
      cur.resValid <= 1'b0;
      cur.resWord <= 1'b0;
      cur.wordSub <= 1'b0;
      cur.wordHigh <= `ALD_BYTE_ZERO;
      cur.lowCarry <= 1'b0;
      cur.ioWrValid <= 1'b0;
      cur.ioWrAddr <= 5'h00;
      cur.ioWrData <= `ALD_BYTE_ZERO;
      cur.ioRefused <= 1'b0;
      cur.flags <= `ALD_FLAGS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs, each straight from a flip-flop
  // ****************************************
  assign opReady = cur.ready;
  assign resultValid = cur.resValid;
  assign resultWord = cur.resWord;
  assign resultLow = cur.resLow;
  assign resultHigh = cur.resHigh;
  assign sreg = cur.sreg;
  assign ioWriteValid = cur.ioWrValid;
  assign ioWriteAddr = cur.ioWrAddr;
  assign ioWriteData = cur.ioWrData;
  assign ioRefused = cur.ioRefused;
  assign flagStatus = cur.flags;

endmodule

/* ald_datapath_asserts.sv */
// Purpose: Port checks of the datapath
// Assumes: Sees ald_datapath ports only
// Notes: Bound below
module ald_datapath_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request
  input wire logic opValid,
  input wire ald_pkg::ald_op_t opCode,
  input wire logic [5:0] ioAddr,
  input wire logic [7:0] flagEvent,
  // Answer
  input wire logic opReady,
  input wire logic resultValid,
  input wire logic resultWord,
  input wire logic [7:0] resultLow,
  input wire logic [7:0] resultHigh,
  input wire logic [7:0] sreg,
  input wire logic ioWriteValid,
  input wire logic ioRefused,
  input wire logic [7:0] flagStatus
);
  import ald_pkg::*;
  logic take, isWord, isBit, isLogic;
  assign take = opValid && opReady;
  assign isWord = opCode inside {OP_WORD_ADD_IMM, OP_WORD_SUB_IMM};
  assign isBit = opCode inside {OP_IO_BIT_CLEAR, OP_IO_BIT_SET};
  assign isLogic = opCode inside {OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_byte_latency: assert property (
    take && !isWord && !isBit && opCode != OP_NONE |=> resultValid && !resultWord) else $error("byte latency");
  chk_word_latency: assert property (
    take && isWord |=> !opReady && !resultValid ##1 resultValid && resultWord && opReady
    && sreg[5] == $past(sreg[5], 2)) else $error("word latency");
  chk_byte_flags: assert property (
    resultValid && !resultWord |-> sreg[1] == (resultLow == 8'h00) && sreg[2] == resultLow[7]) else $error("byte zn");
  chk_word_flags: assert property (
    resultValid && resultWord |-> sreg[1] == ({resultHigh, resultLow} == 16'h0000)
    && sreg[2] == resultHigh[7] && sreg[4] == (sreg[2] ^ sreg[3])) else $error("word flags");
  chk_logic_kept: assert property (
    take && isLogic |=> !sreg[3] && sreg[0] == $past(sreg[0]) && sreg[5:4] == $past(sreg[5:4])) else $error("logic");
  chk_s_kept: assert property (
    take && !isWord |=> sreg[7:6] == $past(sreg[7:6]) && sreg[4] == $past(sreg[4])) else $error("s kept");
  chk_io_write: assert property (
    take && isBit && ioAddr <= 6'h1F |=> ioWriteValid && !ioRefused) else $error("io write");
  chk_io_refuse: assert property (
    take && isBit && ioAddr > 6'h1F |=> ioRefused && !ioWriteValid) else $error("io refuse");
  chk_flag_set: assert property (
    |flagEvent |=> (flagStatus & $past(flagEvent)) == $past(flagEvent)) else $error("flag set");
endmodule

bind ald_datapath ald_datapath_asserts i_ald_datapath_asserts (.mclk(mclk), .rst(rst), .opValid(opValid),
  .opCode(opCode), .ioAddr(ioAddr), .flagEvent(flagEvent), .opReady(opReady), .resultValid(resultValid),
  .resultWord(resultWord), .resultLow(resultLow), .resultHigh(resultHigh), .sreg(sreg),
  .ioWriteValid(ioWriteValid), .ioRefused(ioRefused), .flagStatus(flagStatus));

/* ald_io_model.sv */
// Purpose: Decoder side I/O register for bit operations
// Assumes: One register at IO_ADDR
// Notes: Writes to other addresses are dropped
module ald_io_model #(
  parameter logic [4:0] IO_ADDR = 5'h1F,
  parameter logic [7:0] INIT = 8'h5A
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Write back
  input wire logic ioWriteValid,
  input wire logic [4:0] ioWriteAddr,
  input wire logic [7:0] ioWriteData,
  // Read value
  output logic [7:0] ioReadData
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ioReadData <= INIT;
    end else if (ioWriteValid && ioWriteAddr == IO_ADDR) begin
      ioReadData <= ioWriteData;
    end
  end
endmodule

/* ald_pkg.sv */
// Purpose: Types of the arithmetic and logic datapath
// Assumes: Constants live in ald_consts.svh
// Notes: Operation codes are set by the instruction decoder
package ald_pkg;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_ADD_CARRY = 4'h2,
    OP_WORD_ADD_IMM = 4'h3,
    OP_SUB = 4'h4,
    OP_SUB_IMM = 4'h5,
    OP_SUB_CARRY = 4'h6,
    OP_SUB_IMM_CARRY = 4'h7,
    OP_WORD_SUB_IMM = 4'h8,
    OP_AND = 4'h9,
    OP_AND_IMM = 4'hA,
    OP_OR = 4'hB,
    OP_OR_IMM = 4'hC,
    OP_XOR = 4'hD,
    OP_IO_BIT_CLEAR = 4'hE,
    OP_IO_BIT_SET = 4'hF
  } ald_op_t;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WORD_HIGH = 2'b10
  } ald_state_t;

  // ****************************************
  // Whole register state of the datapath
  // ****************************************
  typedef struct packed {
    ald_state_t state;
    logic ready;
    logic [7:0] sreg;
    logic [7:0] resLow;
    logic [7:0] resHigh;
    logic resValid;
    logic resWord;
    logic wordSub;
    logic [7:0] wordHigh;
    logic lowCarry;
    logic ioWrValid;
    logic [4:0] ioWrAddr;
    logic [7:0] ioWrData;
    logic ioRefused;
    logic [7:0] flags;
  } ald_regs_t;

endpackage

/* testbench.sv */
// Purpose: Self-checking bench of the datapath
// Assumes: ald_io_model is the decoder side register
// Notes: Table flags chain entry to entry
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ald_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, opValid = 1'b0;
  ald_op_t opCode = OP_NONE;
  logic [7:0] opDst = 8'h00, opDstHigh = 8'h00, opSrc = 8'h00, flagEvent = 8'h00;
  logic [5:0] ioAddr = 6'h00;
  logic [2:0] ioBitSel = 3'h0;
  logic opReady, resultValid, resultWord, ioWriteValid, ioRefused;
  logic [7:0] resultLow, resultHigh, sreg, ioWriteData, flagStatus, ioReadData;
  logic [4:0] ioWriteAddr;
  int mismatches = 0, n_compared = 0;
  always #4 mclk = ~mclk;
  ald_datapath #(.FLAG_IO_ADDR(5'h0E)) i_ald_datapath (.mclk(mclk), .rst(rst), .opValid(opValid),
    .opCode(opCode), .opDst(opDst), .opDstHigh(opDstHigh), .opSrc(opSrc), .ioAddr(ioAddr),
    .ioBitSel(ioBitSel), .ioReadData(ioReadData), .flagEvent(flagEvent), .opReady(opReady),
    .resultValid(resultValid), .resultWord(resultWord), .resultLow(resultLow), .resultHigh(resultHigh),
    .sreg(sreg), .ioWriteValid(ioWriteValid), .ioWriteAddr(ioWriteAddr), .ioWriteData(ioWriteData),
    .ioRefused(ioRefused), .flagStatus(flagStatus));
  ald_io_model i_ald_io_model (.mclk(mclk), .rst(rst), .ioWriteValid(ioWriteValid),
    .ioWriteAddr(ioWriteAddr), .ioWriteData(ioWriteData), .ioReadData(ioReadData));
  task automatic end_sim;
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ********
  // One request, answer sampled at the edge that ends it
  // ********
  task automatic issue(ald_op_t c, logic [7:0] d, logic [7:0] h, logic [7:0] s);
    int n;
    opValid <= 1'b1;
    opCode <= c;
    opDst <= d;
    opDstHigh <= h;
    opSrc <= s;
    // Strobe dropped once, so a following call never lowers and raises it in one step
    @(posedge mclk);
    opValid <= 1'b0;
    for (n = 0; n < 3; n++) begin
      @(posedge mclk);
      if ((resultValid | ioWriteValid | ioRefused) === 1'b1) break;
    end
    if (n == 3) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic s_arith;
    logic [51:0] t [15] = '{52'h17F000100802C, 52'h1FF0001000023, 52'h9F0000F000023, 52'h2100020003100,
      52'h400000100FF25, 52'h710000F000022, 52'h6050002000300, 52'h5800001007F28, 52'hC000000000022,
      52'hDAA005500FF24, 52'hB800001008124, 52'hA0F00F0000022, 52'h80000C1FFFF35, 52'h1010001000210,
      52'h3FF7F0180000C};
    logic [25:0] g;
    logic [25:0] e;
    foreach (t[i]) begin
      issue(ald_op_t'(t[i][51:48]), t[i][47:40], t[i][39:32], t[i][31:24]);
      g = {opReady, resultWord, resultWord ? resultHigh : 8'h00, resultLow, sreg};
      e = {1'b1, t[i][51:48] inside {4'h3, 4'h8}, t[i][23:0]};
      `CHK(g, e)
    end
  endtask
  task automatic s_io;
    flagEvent <= 8'hC3;
    @(posedge mclk);
    flagEvent <= 8'h00;
    @(posedge mclk);
    `CHK(flagStatus, 8'hC3)
    ioAddr <= 6'h0E;
    ioBitSel <= 3'h2; // Sets bit 2; the rewrite clears every raised flag
    issue(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00);
    `CHK({ioWriteAddr, ioWriteData, flagStatus}, {5'h0E, 8'hC7, 8'h00})
    flagEvent <= 8'hC3;
    @(posedge mclk);
    flagEvent <= 8'h00;
    ioBitSel <= 3'h0;
    issue(OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00);
    `CHK({ioWriteData, flagStatus}, {8'hC2, 8'h01})
    ioAddr <= 6'h1F;
    ioBitSel <= 3'h7;
    issue(OP_IO_BIT_SET, 8'h00, 8'h00, 8'h00);
    `CHK({ioWriteAddr, ioWriteData}, {5'h1F, 8'hDA})
    ioAddr <= 6'h20;
    issue(OP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00);
    `CHK({ioRefused, ioWriteValid, ioReadData}, {2'b10, 8'hDA})
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    s_arith();
    s_io();
    end_sim();
  end
endmodule
